// file: rtl/lcd_slave_defines.svh
// constants of the two-wire receive front end of the segment display driver
// assumes one 250 MHz clock and the bus lines sampled through synchronisers
//
// What this block does
// RQ1: data stable while clock high, else condition
// RQ2: idle bus has both lines high
// RQ3: data falling while clock high means START
// RQ4: data rising while clock high means STOP
// RQ5: master starts only on idle bus
// RQ6: eight bits per byte, then acknowledge cycle
// RQ7: matched device acknowledges every received byte
// RQ8: acknowledge holds data low through clock high
// RQ9: master nack on read; device releases line
// RQ10: slave only; drives acks and temperature
// RQ11: address 01110, straps, read/write flag
// RQ12: strap mismatch ignores transfer until condition
// RQ13: control bit 6 picks command or RAM
// RQ14: control bit 7 says another control follows
// RQ15: display byte goes to data pointer location
// RQ16: master ends with STOP or repeated START
// RQ17: read flag set returns temperature byte
// RQ18: RAM write at eighth bit, command at ack
// RQ19: pointer steps by mode, wraps at row end
// RQ20: cut-short access leaves pointer undefined
// RQ21: after last control, all bytes to path
`ifndef LCD_SLAVE_DEFINES_SVH
`define LCD_SLAVE_DEFINES_SVH
// ************************************************************
// address and control byte layout
// ************************************************************
`define ADDR_FIXED      5'h0E
`define ADDR_FIXED_HI   7
`define ADDR_FIXED_LO   3
`define ADDR_RW_BIT     0
`define ADDR_STRAP_HI   2
`define ADDR_STRAP_LO   1
`define CTRL_FURTHER    7
`define CTRL_TARGET     6
`define BIT_LAST        3'h7
`define BIT_FIRST       3'h0
`define TX_RELEASED     8'hFF
// ************************************************************
// display RAM pointer
// ************************************************************
`define PTR_W           6
`define ROW_LAST        6'h3B
`define PTR_RESET       6'h00
`define STEP_STATIC     6'h08
`define STEP_MUX2       6'h04
`define STEP_MUX4       6'h02
`define STEP_MUX8       6'h01
`define MODE_STATIC     3'h0
`define MODE_MUX2       3'h1
`define MODE_MUX4       3'h2
`define MODE_MUX6       3'h3
`define MODE_MUX8       3'h4
`endif

// file: rtl/lcd_slave_pkg.sv
// types of the two-wire receive front end
// assumes lcd_slave_defines.svh is in the include path
package lcd_slave_pkg;
   // byte handed to the command path
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } byte_out_t;
   typedef struct packed {
      logic                 we;
      logic [5:0]           addr;
      logic [7:0]           data;
   } ram_wr_t;
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_ADDR = 6'b000010,
      ST_CTRL = 6'b000100,
      ST_DATA = 6'b001000,
      ST_READ = 6'b010000,
      ST_SKIP = 6'b100000
   } phase_t;
endpackage

// file: rtl/line_sync.sv
// three-flop synchroniser for one bus line with a two-stage agreement filter
// assumes the line is asynchronous to mclk and idles high
`timescale 1ns/1ps
module line_sync (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic line_in,
   output logic      line_out
);
   logic s1_q, s2_q, s3_q, out_q, out_d;
   // accept a new level only once the second and third stages agree
   always_comb begin
      out_d = (s2_q == s3_q) ? s3_q : out_q;
   end
   // idle bus is high, so reset to high
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q  <= 1'b1;
         s2_q  <= 1'b1;
         s3_q  <= 1'b1;
         out_q <= 1'b1;
      end else begin
         s1_q  <= line_in;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         out_q <= out_d;
      end
   end
   assign line_out = out_q;
endmodule // line_sync

// file: rtl/lcd_i2c_front.sv
// receive-mostly two-wire slave: START/STOP, address match, control byte parsing,
// command bytes, display RAM writes with pointer stepping, one temperature byte read
// assumes external pull-ups; sda_oe high pulls the data line low
`timescale 1ns/1ps
`include "lcd_slave_defines.svh"
module lcd_i2c_front
   import lcd_slave_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       addr_strap_low,
   input  wire logic       addr_strap_high,
   input  wire logic [7:0] temperature_byte,
   input  wire logic [2:0] mux_mode,
   input  wire logic       ptr_load,
   input  wire logic [5:0] ptr_value,
   output byte_out_t       cmd_out,
   output ram_wr_t         ram_wr,
   output logic [5:0]      data_ptr,
   output logic            bus_busy
);
   logic scl_s, sda_s;
   line_sync u_scl (.mclk(mclk), .rst_n(rst_n), .line_in(scl_in), .line_out(scl_s));
   line_sync u_sda (.mclk(mclk), .rst_n(rst_n), .line_in(sda_in), .line_out(sda_s));
   // straps are pins too; they settle long before any address byte arrives
   logic strap_lo_s, strap_hi_s;
   line_sync u_strap_lo (.mclk(mclk), .rst_n(rst_n), .line_in(addr_strap_low),
      .line_out(strap_lo_s));
   line_sync u_strap_hi (.mclk(mclk), .rst_n(rst_n), .line_in(addr_strap_high),
      .line_out(strap_hi_s));

   // ************************************************************
   // pointer step per drive mode
   // ************************************************************
   // 1:6 mode alternates one and two; toggle tracks which
   function automatic logic [5:0] ptr_step(input logic [2:0] m, input logic alt);
      case (m)
         `MODE_STATIC: ptr_step = `STEP_STATIC;
         `MODE_MUX2:   ptr_step = `STEP_MUX2;
         `MODE_MUX4:   ptr_step = `STEP_MUX4;
         `MODE_MUX6:   ptr_step = alt ? `STEP_MUX4 : `STEP_MUX8;
         default:      ptr_step = `STEP_MUX8;
      endcase
   endfunction

   // ************************************************************
   // bus condition detection
   // ************************************************************
   logic scl_p_q, sda_p_q;
   logic start_c, stop_c, scl_rise, scl_fall;
   always_comb begin
      start_c  = scl_s && scl_p_q && sda_p_q && !sda_s;   // RQ3 RQ1
      stop_c   = scl_s && scl_p_q && !sda_p_q && sda_s;   // RQ4 RQ1
      scl_rise = scl_s && !scl_p_q;
      scl_fall = !scl_s && scl_p_q;
   end

   // ************************************************************
   // byte engine state
   // ************************************************************
   phase_t     ph_q, ph_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic       ack_q, ack_d;       // in acknowledge slot
   logic       last_q, last_d;     // last control byte seen
   logic       tgt_q, tgt_d;       // 1 = display RAM
   logic       nxt_ctrl_q, nxt_ctrl_d;
   logic       oe_q, oe_d, out_q, out_d;
   logic       busy_q, busy_d;
   logic       alt_q, alt_d;
   logic [5:0] ptr_q, ptr_d;
   byte_out_t  cmd_q, cmd_d;
   ram_wr_t    ram_q, ram_d;
   logic [7:0] tx_q, tx_d;
   logic [7:0] rx_byte;
   logic [5:0] step, ptr_sum;

   // next-state logic for the whole receive path
   always_comb begin
      ph_d = ph_q; bit_d = bit_q; sh_d = sh_q; ack_d = ack_q;
      last_d = last_q; tgt_d = tgt_q; nxt_ctrl_d = nxt_ctrl_q;
      oe_d = oe_q; out_d = 1'b0; busy_d = busy_q; alt_d = alt_q; ptr_d = ptr_q;
      tx_d = tx_q;
      cmd_d = '0; ram_d = '0;
      rx_byte = {sh_q[6:0], sda_s};
      step    = ptr_step(mux_mode, alt_q);
      ptr_sum = 6'(ptr_q + step);
      if (ptr_load) begin
         ptr_d = ptr_value;
         alt_d = 1'b0;
      end
      if (start_c) begin                     // RQ3 RQ16 also repeated START
         // the clock fall that closes START carries no bit; treating it as the end
         // of an acknowledge slot keeps it off the bit counter
         ph_d = ST_ADDR; bit_d = `BIT_FIRST; ack_d = 1'b1; oe_d = 1'b0;
         last_d = 1'b0; busy_d = 1'b1;
      end else if (stop_c) begin             // RQ4 release and go idle
         ph_d = ST_IDLE; oe_d = 1'b0; ack_d = 1'b0; busy_d = 1'b0;  // RQ2
      end else if (ph_q != ST_IDLE && ph_q != ST_SKIP) begin
         if (scl_rise && !ack_q) begin       // RQ6 sample one bit per clock
            sh_d = rx_byte;
            if (bit_q == `BIT_LAST && ph_q == ST_DATA && tgt_q && !ptr_load) begin
               // RQ18 store at the eighth bit, not at the acknowledge
               ram_d.we = 1'b1; ram_d.addr = ptr_q; ram_d.data = rx_byte;  // RQ15
               ptr_d = (ptr_sum > `ROW_LAST || ptr_sum < ptr_q) ? `PTR_RESET
                                                                 : ptr_sum; // RQ19
               alt_d = !alt_q;
            end
         end else if (scl_rise && ack_q && ph_q == ST_READ) begin
            if (sda_s) ph_d = ST_SKIP;       // RQ9 master nack ends read
         end else if (scl_fall) begin
            if (ack_q) begin
               // leaving acknowledge slot
               ack_d = 1'b0; bit_d = `BIT_FIRST;
               oe_d = 1'b0;
               if (ph_q == ST_READ) begin
                  oe_d = !tx_q[7];            // RQ17 shift out temperature
                  tx_d = {tx_q[6:0], 1'b1};   // after one byte only ones: released
               end
            end else if (bit_q == `BIT_LAST) begin
               ack_d = 1'b1; oe_d = 1'b0;
               case (ph_q)
                  ST_ADDR: begin
                     if (sh_q[`ADDR_FIXED_HI:`ADDR_FIXED_LO] == `ADDR_FIXED &&
                         sh_q[`ADDR_STRAP_HI] == strap_hi_s &&
                         sh_q[`ADDR_STRAP_LO] == strap_lo_s) begin   // RQ11
                        oe_d = 1'b1;                        // RQ7 RQ8
                        if (sh_q[`ADDR_RW_BIT]) begin
                           ph_d = ST_READ; tx_d = temperature_byte;  // RQ17
                        end else begin
                           ph_d = ST_CTRL;
                        end
                     end else begin
                        ph_d = ST_SKIP; ack_d = 1'b0;       // RQ12
                     end
                  end
                  ST_CTRL: begin
                     oe_d = 1'b1;                           // RQ7
                     tgt_d = sh_q[`CTRL_TARGET];            // RQ13
                     nxt_ctrl_d = sh_q[`CTRL_FURTHER];      // RQ14
                     last_d = !sh_q[`CTRL_FURTHER];
                     ph_d = ST_DATA;
                  end
                  ST_DATA: begin
                     oe_d = 1'b1;                           // RQ7
                     if (!tgt_q) begin
                        cmd_d.valid = 1'b1; cmd_d.data = sh_q;   // RQ18 command at ack
                     end
                     ph_d = (nxt_ctrl_q && !last_q) ? ST_CTRL : ST_DATA;  // RQ14 RQ21
                  end
                  ST_READ: begin
                     ack_d = 1'b1;                          // RQ10 master acknowledges
                  end
                  default: ph_d = ST_SKIP;
               endcase
            end else begin
               bit_d = 3'(bit_q + 3'h1);
               if (ph_q == ST_READ) begin
                  oe_d = !tx_q[7];                         // RQ10
                  tx_d = {tx_q[6:0], 1'b1};
               end
            end
         end
      end
   end

   // register stage
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scl_p_q <= 1'b1; sda_p_q <= 1'b1;
         ph_q <= ST_IDLE; bit_q <= `BIT_FIRST; sh_q <= 8'h00;
         ack_q <= 1'b0; last_q <= 1'b0; tgt_q <= 1'b0;
         nxt_ctrl_q <= 1'b0; oe_q <= 1'b0; out_q <= 1'b0; busy_q <= 1'b0;
         alt_q <= 1'b0; ptr_q <= `PTR_RESET; tx_q <= `TX_RELEASED;
         cmd_q <= '0; ram_q <= '0;
      end else begin
         scl_p_q <= scl_s; sda_p_q <= sda_s;
         ph_q <= ph_d; bit_q <= bit_d; sh_q <= sh_d;
         ack_q <= ack_d; last_q <= last_d; tgt_q <= tgt_d;
         nxt_ctrl_q <= nxt_ctrl_d; oe_q <= oe_d; out_q <= out_d; busy_q <= busy_d;
         alt_q <= alt_d; ptr_q <= ptr_d; tx_q <= tx_d;
         cmd_q <= cmd_d; ram_q <= ram_d;
      end
   end

   assign sda_out  = out_q;   // always low; only the enable moves
   assign sda_oe   = oe_q;
   assign cmd_out  = cmd_q;
   assign ram_wr   = ram_q;
   assign data_ptr = ptr_q;
   assign bus_busy = busy_q;

   // ************************************************************
   // checks
   // ************************************************************
   a_start_busy: assert property (@(posedge mclk) disable iff (!rst_n)
      start_c |=> bus_busy && ph_q == ST_ADDR) else $error("start not taken"); // RQ3
   a_stop_idle: assert property (@(posedge mclk) disable iff (!rst_n)
      stop_c |=> !bus_busy && !sda_oe) else $error("stop not taken"); // RQ4
   a_idle_release: assert property (@(posedge mclk) disable iff (!rst_n)
      ph_q == ST_IDLE |-> !sda_oe) else $error("driving while idle"); // RQ2
   a_skip_silent: assert property (@(posedge mclk) disable iff (!rst_n)
      ph_q == ST_SKIP |-> !sda_oe) else $error("drives while ignored"); // RQ12
   a_ack_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      (ack_q && sda_oe && ph_q != ST_READ && scl_s && !start_c && !stop_c)
      |=> sda_oe || stop_c || $past(scl_fall) || $past(start_c)) else $error("ack dropped"); // RQ8
   a_ram_ptr: assert property (@(posedge mclk) disable iff (!rst_n)
      ram_wr.we |-> ram_wr.addr == $past(data_ptr)) else $error("ram addr wrong"); // RQ15
   a_ptr_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
      data_ptr <= `ROW_LAST) else $error("pointer beyond row"); // RQ19
   a_ram_no_ack: assert property (@(posedge mclk) disable iff (!rst_n)
      ram_wr.we |-> !ack_q && !cmd_out.valid) else $error("ram write at ack"); // RQ18
   a_cmd_at_ack: assert property (@(posedge mclk) disable iff (!rst_n)
      cmd_out.valid |-> ack_q && !tgt_q) else $error("command off ack"); // RQ13
   a_ack_drive: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(sda_oe) && ph_q != ST_READ |-> ack_q) else $error("drive outside ack"); // RQ10
   c_write_ram: cover property (@(posedge mclk) disable iff (!rst_n) ram_wr.we);
   c_command: cover property (@(posedge mclk) disable iff (!rst_n) cmd_out.valid);
   c_read: cover property (@(posedge mclk) disable iff (!rst_n) ph_q == ST_READ);
   c_skip: cover property (@(posedge mclk) disable iff (!rst_n) ph_q == ST_SKIP);
   c_restart: cover property (@(posedge mclk) disable iff (!rst_n) start_c && bus_busy);
   a_drive_only_read: assert property (@(posedge mclk) disable iff (!rst_n)
      sda_oe && !ack_q |-> ph_q == ST_READ) else $error("data driven outside read"); // RQ10
endmodule // lcd_i2c_front

// file: tb/bus_master_model.sv
// two-wire bus master model pulling the clock and data lines low on demand
// assumes the bench resolves the wired levels with pull-ups and feeds sda_line back
`timescale 1ns/1ps
module bus_master_model (
   input  wire logic mclk,
   input  wire logic sda_line,
   output logic      scl_low,
   output logic      sda_low
);
   // ************************************************************
   // line timing
   // ************************************************************
   // both lines released at time zero so the bus starts idle
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // five mclk per quarter bit keeps each phase above the input filter
   task automatic wait_q(input int n);
      repeat (5 * n) @(posedge mclk);
   endtask
   // ************************************************************
   // conditions and bits
   // ************************************************************
   // data released while clock low first, so this also serves as repeated start
   task automatic start_cond();
      sda_low <= 1'b0;
      wait_q(2);
      scl_low <= 1'b0;
      wait_q(2);
      sda_low <= 1'b1;
      wait_q(2);
      scl_low <= 1'b1;
   endtask
   // data rises only once the clock is back high
   task automatic stop_cond();
      wait_q(1);
      sda_low <= 1'b1;
      wait_q(1);
      scl_low <= 1'b0;
      wait_q(2);
      sda_low <= 1'b0;
      wait_q(2);
   endtask
   // data moves a quarter into the low phase, never while the clock is high
   task automatic send_bit(input logic v, output logic s);
      wait_q(1);
      sda_low <= ~v;
      wait_q(1);
      scl_low <= 1'b0;
      wait_q(2);
      s = sda_line;
      scl_low <= 1'b1;
   endtask
   // eight bits msb first, then a released ninth bit for the answer
   task automatic write_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) send_bit(b[i], s);
      send_bit(1'b1, s);
      ack = ~s;
   endtask
   // a read always ends with a nack, the line level then shows the release
   task automatic read_byte(output logic [7:0] b, output logic rel);
      for (int i = 7; i >= 0; i--) send_bit(1'b1, b[i]);
      send_bit(1'b1, rel);
   endtask
endmodule // bus_master_model

// file: tb/lcd_i2c_front_tb.sv
// self-checking bench for the two-wire receive front end
// assumes the bus master model drives the lines and the design's inputs come from here
`timescale 1ns/1ps
module lcd_i2c_front_tb;
   import lcd_slave_pkg::*;
   logic       mclk, rst_n, addr_strap_low, addr_strap_high, ptr_load, sda_out, sda_oe;
   logic       bus_busy, scl_low, sda_low, ack, rel, alt;
   logic [7:0] temperature_byte, d;
   logic [2:0] mux_mode;
   logic [5:0] ptr_value, data_ptr, exp_ptr;
   logic [31:0] seed, r;
   byte_out_t  cmd_out;
   ram_wr_t    ram_wr;
   logic [14:0] exp_q[$];
   int         miscompares, check_count;
   wire logic  scl_in = ~scl_low;
   wire logic  sda_in = ~(sda_low | (sda_oe & ~sda_out));
   // ************************************************************
   // design, partner and clock
   // ************************************************************
   lcd_i2c_front i_lcd_i2c_front (.mclk(mclk), .rst_n(rst_n), .scl_in(scl_in),
      .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_low(addr_strap_low),
      .addr_strap_high(addr_strap_high), .temperature_byte(temperature_byte),
      .mux_mode(mux_mode), .ptr_load(ptr_load), .ptr_value(ptr_value), .cmd_out(cmd_out),
      .ram_wr(ram_wr), .data_ptr(data_ptr), .bus_busy(bus_busy));
   bus_master_model i_bus_master_model (.mclk(mclk), .sda_line(sda_in), .scl_low(scl_low),
      .sda_low(sda_low));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // ************************************************************
   // compare helpers and verdict
   // ************************************************************
   task automatic check(input logic [14:0] got, input logic [14:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic pop(input logic [14:0] got);
      check(got, (exp_q.size() > 0) ? exp_q.pop_front() : 15'h7FFF);
   endtask
   task automatic final_report();
      if (miscompares == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // own pointer model: mode step, 1:6 alternating from +1, wrap past the row end
   function automatic logic [5:0] next_ptr(input logic [5:0] p, input logic [2:0] m);
      logic [6:0] n;
      n = {1'b0, p} + ((m == 3'h0) ? 7'h08 : (m == 3'h1) ? 7'h04 : (m == 3'h2) ? 7'h02 :
          (m == 3'h3 && alt) ? 7'h02 : 7'h01);
      if (m == 3'h3) alt = ~alt;
      return (n > 7'h3B) ? 6'h00 : n[5:0];
   endfunction
   // results appear in byte order, so one queue serves both paths
   always @(posedge mclk) begin
      if (ram_wr.we === 1'b1) begin
         pop({1'b1, ram_wr.addr, ram_wr.data});
         check({14'h0000, scl_in}, 15'h0001);
      end
      if (cmd_out.valid === 1'b1) pop({1'b0, 6'h00, cmd_out.data});
   end
   // ************************************************************
   // scenarios
   // ************************************************************
   // load the pointer near the row end so six writes cross the wrap (in 1:8 mode only from 6'h36 up), then open a write
   task automatic open_write(input logic [2:0] mode, input logic strap_bad);
      r = $random(seed);
      mux_mode <= mode;
      ptr_load <= 1'b1;
      ptr_value <= 6'h34 + {3'h0, r[2:0]};
      exp_ptr = 6'h34 + {3'h0, r[2:0]};
      alt = 1'b0;
      addr_strap_low <= r[3];
      addr_strap_high <= r[4];
      temperature_byte <= r[12:5];
      @(posedge mclk);
      ptr_load <= 1'b0;
      i_bus_master_model.start_cond();
      check({14'h0000, bus_busy}, 15'h0001);
      i_bus_master_model.write_byte({5'h0E, r[4] ^ strap_bad, r[3], 1'b0}, ack);
      check({14'h0000, ack}, {14'h0000, ~strap_bad});
   endtask
   // send a data or command byte and note what should come out of it
   task automatic send_data(input logic to_ram, input logic expect_out);
      d = $random(seed);
      if (expect_out) exp_q.push_back(to_ram ? {1'b1, exp_ptr, d} : {7'h00, d});
      if (expect_out && to_ram) exp_ptr = next_ptr(exp_ptr, mux_mode);
      i_bus_master_model.write_byte(d, ack);
      check({14'h0000, ack}, {14'h0000, expect_out});
   endtask
   task automatic send_ctrl(input logic [7:0] c);
      i_bus_master_model.write_byte(c | {2'b00, r[18:13]}, ack);
      check({14'h0000, ack}, 15'h0001);
   endtask
   task automatic close_check();
      i_bus_master_model.stop_cond();
      check({8'h00, bus_busy, data_ptr}, {9'h000, exp_ptr});
      check(15'(exp_q.size()), 15'h0000);
   endtask
   initial begin
      seed = 32'hAAC09828;
      rst_n = 1'b0;
      {addr_strap_low, addr_strap_high, ptr_load, temperature_byte} = '0;
      mux_mode = 3'h0;
      ptr_value = 6'h00;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (8) @(posedge mclk);
      check({7'h00, bus_busy, sda_oe, data_ptr}, 15'h0000);
      for (int m = 0; m < 5; m++) begin
         open_write(m[2:0], 1'b0);
         send_ctrl(8'h40);
         repeat (6) send_data(1'b1, 1'b1);
         close_check();
      end
      open_write(3'h4, 1'b0);
      send_ctrl(8'h80);
      send_data(1'b0, 1'b1);
      send_ctrl(8'hC0);
      send_data(1'b1, 1'b1);
      send_ctrl(8'h00);
      repeat (3) send_data(1'b0, 1'b1);
      i_bus_master_model.start_cond();
      i_bus_master_model.write_byte({5'h0E, r[4], r[3], 1'b1}, ack);
      check({14'h0000, ack}, 15'h0001);
      i_bus_master_model.read_byte(d, rel);
      check({6'h00, rel, d}, {6'h00, 1'b1, r[12:5]});
      close_check();
      open_write(3'h2, 1'b1);
      send_data(1'b1, 1'b0);
      send_data(1'b1, 1'b0);
      close_check();
      final_report();
   end
   // run is about 10200 cycles, so nearly six times that means a hang
   initial begin
      repeat (60000) @(posedge mclk);
      miscompares++;
      final_report();
   end
endmodule // lcd_i2c_front_tb
